// >>> core/seq_step_pkg.sv
// Package with register map, field layout and encodings of the sequence step configuration.
package seq_step_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  // Printed offsets are not all multiples of four, so they are indices.
  localparam logic [7:0]  step_one_index   = 8'hd1;
  localparam logic [7:0]  step_two_index   = 8'hd2;
  localparam int          addr_width       = 10;
  localparam logic [15:0] step_one_reset   = 16'h0001;
  localparam logic [15:0] step_two_reset   = 16'h0002;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int          enable_bit       = 15;
  localparam int          gain_hi          = 14;
  localparam int          gain_lo          = 13;
  localparam int          negative_bit     = 4;
  localparam int          positive_hi      = 3;
  localparam int          positive_lo      = 0;
  localparam logic [15:0] writable_mask    = 16'he01f;

  // ****************************************************************
  // AXI responses
  // ****************************************************************
  localparam logic [1:0]  resp_okay        = 2'h0;
  localparam logic [1:0]  resp_slverr      = 2'h2;

  // Gain seen by the converter.
  typedef enum logic [1:0] {
    gain_x1 = 2'h0,
    gain_x2 = 2'h1,
    gain_x4 = 2'h2
  } gain_e;

  // Source routed to the converter's positive input.
  typedef enum logic [3:0] {
    pos_ext0     = 4'h0,
    pos_ext7     = 4'h7,
    pos_temp     = 4'h8,
    pos_short    = 4'h9,
    pos_test_dac = 4'ha,
    pos_analog_supply_q       = 4'hb,
    pos_io_supply_q           = 4'hc,
    pos_digital_core_supply_h = 4'hd,
    pos_analog_power_input    = 4'he,
    pos_digital_power_input   = 4'hf
  } positive_e;

  // Source routed to the converter's negative input.
  typedef enum logic [1:0] {
    neg_ground = 2'h0,
    neg_ext7   = 2'h1,
    neg_auto   = 2'h2
  } negative_e;

  // Byte address of a register index.
  function automatic logic [addr_width-1:0] byte_addr(input logic [7:0] index);
    byte_addr = {index, 2'h0};
  endfunction

endpackage

// >>> core/step_decode.sv
// Decoder from a step configuration word to converter routing controls.
`timescale 1ns/1ps
module step_decode
  import seq_step_pkg::*;
(
  // Configuration word
  input  wire logic [15:0] config_word,
  // Routing controls
  output logic             step_included,
  output gain_e            gain,
  output positive_e        positive_source,
  output negative_e        negative_source,
  output logic [2:0]       external_index
);

  always_comb begin
    // RULE_01: step inclusion enable.
    step_included = config_word[enable_bit];
    // RULE_02: gain code mapping.
    case (config_word[gain_hi:gain_lo])
      2'h0:    gain = gain_x1;
      2'h1:    gain = gain_x2;
      default: gain = gain_x4;
    endcase
    // RULE_04: external input selection.
    // RULE_06: internal source selection.
    positive_source = positive_e'(config_word[positive_hi:positive_lo]);
    external_index  = config_word[2:0];
    // RULE_05: automatic negative for internals.
    // RULE_03: negative input selection.
    if (config_word[positive_hi]) begin
      negative_source = neg_auto;
    end else if (config_word[negative_bit]) begin
      negative_source = neg_ext7;
    end else begin
      negative_source = neg_ground;
    end
  end

endmodule // step_decode

// >>> core/seq_step_regs.sv
// AXI4-Lite register block for sequence steps one and two of the second converter.
//
// Overview of operation
// RULE_01: Bit 15 includes step one when set.
// RULE_02: Gain code 00/01/1x gives 1/2/4.
// RULE_03: Bit 4 selects ground or input seven.
// RULE_04: Codes 0..7 select external inputs zero..seven.
// RULE_05: Codes 8..15 choose negative automatically.
// RULE_06: Codes 8..15 route internal sources.
// RULE_07: Step one at D1h, resets 0001h.
// RULE_08: Step two at D2h, resets 0002h.
// RULE_09: Bits 12..5 ignore writes, read zero.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module seq_step_regs
  import seq_step_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  // AXI4-Lite write address
  input  wire logic [addr_width-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [addr_width-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Step one converter controls
  output logic                       step_one_included,
  output gain_e                      step_one_gain,
  output positive_e                  step_one_positive_select,
  output negative_e                  step_one_negative_select,
  output logic [2:0]                 step_one_external_index,
  // Step two raw configuration
  output logic [15:0]                step_two_config
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [15:0]           sequence_step_one_config;
  logic [15:0]           sequence_step_two_config;
  logic [15:0]           next_step_one;
  logic [15:0]           next_step_two;
  logic                  aw_held;
  logic                  w_held;
  logic [addr_width-1:0] aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  next_aw_held;
  logic                  next_w_held;
  logic [addr_width-1:0] next_aw_addr;
  logic [31:0]           next_w_data;
  logic [3:0]            next_w_strb;
  logic                  next_bvalid;
  logic [1:0]            next_bresp;
  logic                  next_rvalid;
  logic [31:0]           next_rdata;
  logic [1:0]            next_rresp;
  logic                  do_write;

  // Merge a write under byte strobes, keeping only the writable bits.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & writable_mask;
    merge = (old & ~lanes) | (data[15:0] & lanes);
  endfunction

  // An access hits a register when its word address matches the index; bits 1:0 are ignored.
  function automatic logic addr_hits(input logic [addr_width-1:0] addr,
                                     input logic [7:0]            index);
    addr_hits = (addr[addr_width-1:2] == index);
  endfunction

  // The slave holds one address and one data beat, and stalls both until the response drains.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    next_aw_held  = aw_held;
    next_w_held   = w_held;
    next_aw_addr  = aw_addr;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_bvalid   = s_axi_bvalid;
    next_bresp    = s_axi_bresp;
    next_step_one = sequence_step_one_config;
    next_step_two = sequence_step_two_config;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_write = next_aw_held && next_w_held;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = resp_okay;
      // RULE_07: step one write decode.
      // RULE_09: reserved bits masked.
      if (addr_hits(next_aw_addr, step_one_index)) begin
        next_step_one = merge(sequence_step_one_config, next_w_data, next_w_strb);
      // RULE_08: step two write decode.
      end else if (addr_hits(next_aw_addr, step_two_index)) begin
        next_step_two = merge(sequence_step_two_config, next_w_data, next_w_strb);
      end else begin
        next_bresp = resp_slverr;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = resp_okay;
      if (addr_hits(s_axi_araddr, step_one_index)) begin
        next_rdata = {16'h0000, sequence_step_one_config};
      end else if (addr_hits(s_axi_araddr, step_two_index)) begin
        next_rdata = {16'h0000, sequence_step_two_config};
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = resp_slverr;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      // RULE_07: step one reset value.
      sequence_step_one_config <= step_one_reset;
      // RULE_08: step two reset value.
      sequence_step_two_config <= step_two_reset;
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= resp_okay;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= resp_okay;
    end else begin
      sequence_step_one_config <= next_step_one;
      sequence_step_two_config <= next_step_two;
      aw_held      <= next_aw_held;
      w_held       <= next_w_held;
      aw_addr      <= next_aw_addr;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

  // ****************************************************************
  // Converter controls
  // ****************************************************************
  step_decode u_step_one (
    .config_word     (sequence_step_one_config),
    .step_included   (step_one_included),
    .gain            (step_one_gain),
    .positive_source (step_one_positive_select),
    .negative_source (step_one_negative_select),
    .external_index  (step_one_external_index)
  );

  assign step_two_config = sequence_step_two_config;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_enable_follows: assert property (step_one_included == sequence_step_one_config[15]) // RULE_01
    else $error("step enable does not follow bit 15");
  a_gain_map: assert property ( // RULE_02
    step_one_gain == (sequence_step_one_config[14] ? gain_x4 :
                      (sequence_step_one_config[13] ? gain_x2 : gain_x1)))
    else $error("gain mapping wrong");
  a_negative_manual: assert property ( // RULE_03
    !sequence_step_one_config[3] |->
      step_one_negative_select == (sequence_step_one_config[4] ? neg_ext7 : neg_ground))
    else $error("negative select wrong");
  a_external_index: assert property ( // RULE_04
    !sequence_step_one_config[3] |-> step_one_external_index == sequence_step_one_config[2:0])
    else $error("external input index wrong");
  a_negative_auto: assert property ( // RULE_05
    sequence_step_one_config[3] |-> step_one_negative_select == neg_auto)
    else $error("automatic negative not chosen");
  a_internal_route: assert property ( // RULE_06
    step_one_positive_select == positive_e'(sequence_step_one_config[3:0]))
    else $error("positive source wrong");
  a_step_one_read: assert property ( // RULE_07
    s_axi_arvalid && s_axi_arready && s_axi_araddr == byte_addr(step_one_index) |=>
      s_axi_rvalid && s_axi_rdata == {16'h0000, $past(sequence_step_one_config)})
    else $error("step one readback wrong");
  a_step_two_read: assert property ( // RULE_08
    s_axi_arvalid && s_axi_arready && s_axi_araddr == byte_addr(step_two_index) |=>
      s_axi_rvalid && s_axi_rdata == {16'h0000, $past(sequence_step_two_config)})
    else $error("step two readback wrong");
  a_reserved_zero: assert property ((sequence_step_one_config & ~writable_mask) == 16'h0000) // RULE_09
    else $error("reserved bits not zero");
  a_write_response: assert property (do_write |=> s_axi_bvalid [*1] ##0 !s_axi_awready)
    else $error("write response missing");

  c_write_step_one: cover property (do_write && next_aw_addr == byte_addr(step_one_index));
  c_read_back: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == resp_okay);
  c_internal_source: cover property (step_one_negative_select == neg_auto && step_one_included);
  c_unmapped: cover property (s_axi_bvalid && s_axi_bresp == resp_slverr);

endmodule // seq_step_regs

// >>> bench/tb.sv
// Self-checking bench for the sequence step register block.
`timescale 1ns/1ps
module tb;
  import seq_step_pkg::*;

  // ****************************************************************
  // Signals and bench state
  // ****************************************************************
  logic                  core_clk = 1'b0;
  logic                  nrst     = 1'b0;
  logic [addr_width-1:0] awaddr   = '0;
  logic [addr_width-1:0] araddr   = '0;
  logic [31:0]           wdata    = '0;
  logic [3:0]            wstrb    = '0;
  logic                  awvalid  = 1'b0;
  logic                  wvalid   = 1'b0;
  logic                  bready   = 1'b0;
  logic                  arvalid  = 1'b0;
  logic                  rready   = 1'b0;
  logic                  awready, wready, bvalid, arready, rvalid, inc;
  logic [1:0]            bresp, rresp;
  logic [31:0]           rdata;
  logic [2:0]            ext;
  logic [15:0]           two, m1, m2;
  gain_e                 gain;
  positive_e             pos;
  negative_e             neg;
  logic [31:0]           seed     = 32'hf0137b37;
  logic [1:0]            bq[$];
  logic [33:0]           rq[$];
  int                    n_errors = 0;
  int                    checked  = 0;
  int                    cycles   = 0;

  seq_step_regs seq_step_regs_inst (
    .core_clk(core_clk), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .step_one_included(inc), .step_one_gain(gain), .step_one_positive_select(pos),
    .step_one_negative_select(neg), .step_one_external_index(ext), .step_two_config(two)
  );

  always #50 core_clk = ~core_clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic fail(input string msg);
    n_errors++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask

  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // Compare tasks
  // ****************************************************************
  task automatic chk_b(input logic [1:0] got);
    checked++;
    if (bq.size() == 0 || got !== bq.pop_front()) fail("write response");
  endtask

  task automatic chk_r(input logic [33:0] got);
    checked++;
    if (rq.size() == 0 || got !== rq.pop_front()) fail("read data or response");
  endtask

  // Gain codes 10 and 11 share one setting; internal sources force automatic negative.
  task automatic chk_dec();
    logic [27:0] e;
    e[27] = m1[15];
    e[26:25] = m1[14] ? 2'h2 : {1'b0, m1[13]};
    e[24:21] = m1[3:0];
    e[20:19] = m1[3] ? 2'h2 : {1'b0, m1[4]};
    e[18:0] = {m1[2:0], m2};
    checked++;
    if ({inc, gain, pos, neg, ext, two} !== e) fail("decoded controls");
  endtask

  // ****************************************************************
  // Bus master
  // ****************************************************************
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
    logic pa, pw, pb, h1, h2;
    logic [15:0] nv;
    h1 = (a[9:2] == 8'hd1);
    h2 = (a[9:2] == 8'hd2);
    nv = h1 ? m1 : m2;
    if (s[0]) nv[7:0] = d[7:0];
    if (s[1]) nv[15:8] = d[15:8];
    if (h1) m1 = nv & 16'he01f;
    if (h2) m2 = nv;
    bq.push_back((h1 || h2) ? 2'h0 : 2'h2);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    while (pb) begin
      @(posedge core_clk);
      if (pa && awready) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        pb = 1'b0;
        bready <= 1'b0;
      end
    end
    // One idle edge, so a following call never sets bready again in the same step.
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [9:0] a);
    logic pa, pr;
    if (a[9:2] == 8'hd1) rq.push_back({16'h0, m1, 2'h0});
    else if (a[9:2] == 8'hd2) rq.push_back({16'h0, m2, 2'h0});
    else rq.push_back({32'h0, 2'h2});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    pa = 1'b1;
    pr = 1'b1;
    while (pr) begin
      @(posedge core_clk);
      if (pa && arready) begin
        pa = 1'b0;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        pr = 1'b0;
        rready <= 1'b0;
      end
    end
    @(posedge core_clk);
  endtask

  // Bus responses are judged here, at the edge of each response handshake; decoded controls are checked by chk_dec in the scenarios.
  always @(posedge core_clk) begin
    cycles++;
    if (bvalid && bready) chk_b(bresp);
    if (rvalid && rready) chk_r({rdata, rresp});
    if (cycles == 5000) begin
      n_errors++;
      test_done();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    logic [31:0] r;
    m1 = 16'h0001;
    m2 = 16'h0002;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    chk_dec();
    rd(10'h344);
    rd(10'h348);
    // Every positive code with both negative settings, all gains and enable states.
    for (int i = 0; i < 64; i++) begin
      r = rnd();
      wr(10'h344, {r[31:16], i[5], i[5:4], r[12:5], i[4], i[3:0]}, 4'hf);
      chk_dec();
      rd(10'h344 | 10'(i[1:0]));
    end
    wr(10'h344, 32'hffff_ffff, 4'h1);
    rd(10'h344);
    wr(10'h344, 32'hffff_ffff, 4'h2);
    rd(10'h344);
    chk_dec();
    wr(10'h348, rnd() & 32'h0000_e01f, 4'h3);
    rd(10'h348);
    chk_dec();
    wr(10'h340, rnd(), 4'hf);
    wr(10'h34c, rnd(), 4'hf);
    rd(10'h340);
    rd(10'h34c);
    chk_dec();
    // A second reset in mid-run must restore both registers.
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    m1 = 16'h0001;
    m2 = 16'h0002;
    @(posedge core_clk);
    chk_dec();
    rd(10'h344);
    rd(10'h348);
    @(posedge core_clk);
    test_done();
  end

endmodule // tb
